// ===== include/rx_flag_defs.svh
// Offsets, field positions, reset values, error count limits and clock rate for the receive flag block.
`ifndef RX_FLAG_DEFS_SVH
`define RX_FLAG_DEFS_SVH
`define RFS_OFFSET 8'h00
`define RIE_OFFSET 8'h04
`define CTL_OFFSET 8'h08
`define ERR_OFFSET 8'h0C
`define BIT_OFFSET 8'h10
`define RFS_RESET 8'h00
`define RIE_RESET 8'h00
`define CTL_RESET 8'h00
`define BIT_RESET 16'h0000
`define FLD_WAKEUP 7
`define FLD_STATUS 6
`define FLD_RECEIVER_STATE_SENSITIVITY_HI 5
`define FLD_RECEIVER_STATE_SENSITIVITY_LO 4
`define FLD_TRANSMITTER_STATE_SENSITIVITY_HI 3
`define FLD_TRANSMITTER_STATE_SENSITIVITY_LO 2
`define FLD_OVERRUN 1
`define FLD_RXFULL 0
`define CTL_INIT_REQ 0
`define CTL_WAKE_EN 1
`define CTL_SLEEP 2
`define WARN_LIMIT 9'd96
`define ERR_LIMIT 9'd127
`define BUSOFF_LIMIT 9'd255
`define CAN_CLK_MHZ 100
`endif

// ===== include/rx_flag_pkg.sv
// Types shared by the receive flag block.
package rx_flag_pkg;
  typedef enum logic [1:0] {
    ST_OK,
    ST_WARN,
    ST_ERR,
    ST_BUSOFF
  } err_state_e;
  typedef struct packed {
    logic [4:0] addr;
    logic we;
    logic [3:0] sel;
    logic [31:0] data;
  } wb_req_s;
  typedef struct packed {
    logic bus_activity;
    logic frame_ok;
    logic overrun;
    logic [8:0] rx_err_count;
    logic [8:0] tx_err_count;
  } can_event_s;
endpackage

// ===== hdl/err_state_decode.sv
// Maps an error count to its two-bit state code.
module err_state_decode
  import rx_flag_pkg::*;
#(
  parameter bit IS_RX = 1'b1
) (
  input wire logic [8:0] own_count_in, // Error count of this direction.
  input wire logic [8:0] tx_count_in, // Transmit error count, decides bus-off.
  output err_state_e state_out // Decoded state.
);
`include "rx_flag_defs.svh"
  // Bus-off comes first so the receiver also shows it; on leaving it, each side takes the state of its own count.
  always_comb begin
    if (tx_count_in > `BUSOFF_LIMIT) begin
      state_out = ST_BUSOFF;
    end else if (own_count_in > `ERR_LIMIT) begin
      state_out = ST_ERR;
    end else if (own_count_in > `WARN_LIMIT) begin
      state_out = ST_WARN;
    end else begin
      state_out = ST_OK;
    end
    if (!IS_RX && state_out == ST_BUSOFF) begin
      state_out = ST_BUSOFF;
    end
  end
endmodule // err_state_decode

// ===== hdl/state_change_detect.sv
// Decides whether a state change matters under a two-bit sensitivity.
module state_change_detect
  import rx_flag_pkg::*;
(
  input wire logic [1:0] sens_in, // Sensitivity setting.
  input wire err_state_e old_in, // Shown state.
  input wire err_state_e new_in, // Actual state.
  output logic hit_out // Change raises the status flag.
);
  logic busoff_edge;
  logic err_edge;
  // Entry or exit of a class is seen by comparing membership before and after.
  always_comb begin
    busoff_edge = (old_in == ST_BUSOFF) != (new_in == ST_BUSOFF);
    err_edge = (old_in >= ST_ERR) != (new_in >= ST_ERR);
    case (sens_in)
      2'h1: hit_out = busoff_edge;
      2'h2: hit_out = busoff_edge || err_edge;
      2'h3: hit_out = old_in != new_in;
      default: hit_out = 1'b0;
    endcase
  end
endmodule // state_change_detect

// ===== hdl/rx_flag_status.sv
// Receive flag and status register block with a classic Wishbone slave.
module rx_flag_status
  import rx_flag_pkg::*;
(
  input wire logic clk_in, // CAN clock, 100 MHz.
  input wire logic rst_in, // Asynchronous reset, active high.
  input wire logic wb_cyc_in, // Wishbone cycle.
  input wire logic wb_stb_in, // Wishbone strobe.
  input wire logic wb_we_in, // Wishbone write enable.
  input wire logic [4:0] wb_adr_in, // Wishbone byte address.
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects.
  input wire logic [31:0] wb_dat_in, // Wishbone write data.
  output logic [31:0] wb_dat_out, // Wishbone read data.
  output logic wb_ack_out, // Wishbone acknowledge.
  input wire logic init_acknowledge_in, // Controller has entered init mode.
  input wire logic bus_activity_in, // Activity seen on the CAN bus pin.
  input wire logic frame_ok_in, // Level: good frame waits at the FIFO head.
  input wire logic overrun_in, // Pulse: receive data overrun.
  input wire logic [8:0] rx_err_count_in, // Receive error counter.
  input wire logic [8:0] tx_err_count_in, // Transmit error counter.
  output logic shift_fg_out, // Pulse: move FIFO head into foreground buffer.
  output logic init_request_out, // Init mode request bit.
  output logic sleep_request_out, // Sleep mode request bit.
  output logic [31:0] bit_time_ns_out, // Nominal bit time in ns.
  output logic wakeup_irq_out, // Wake-up interrupt request.
  output logic error_irq_out, // Error interrupt request.
  output logic receive_irq_out // Receive interrupt request.
);
`include "rx_flag_defs.svh"

  // ****************************************
  // Input synchronisers and request decode
  // ****************************************
  logic act_meta_reg;
  logic act_sync_reg;
  wb_req_s req;
  can_event_s evt;
  logic wb_hit;
  logic wr_en;
  logic in_init;
  logic out_init;

  // The bus pin is asynchronous, so two flops come before any use.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_meta_reg <= 1'b0;
      act_sync_reg <= 1'b0;
    end else begin
      act_meta_reg <= bus_activity_in;
      act_sync_reg <= act_meta_reg;
    end
  end

  // Group bus and link inputs for readability.
  always_comb begin
    req = '{addr: wb_adr_in, we: wb_we_in, sel: wb_sel_in, data: wb_dat_in};
    evt = '{bus_activity: act_sync_reg, frame_ok: frame_ok_in, overrun: overrun_in,
            rx_err_count: rx_err_count_in, tx_err_count: tx_err_count_in};
  end

  // A write lands once, in the cycle the ack is raised.
  assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wr_en = wb_hit && req.we && req.sel[0];
  assign in_init = init_request_out && init_acknowledge_in;
  assign out_init = !init_request_out && !init_acknowledge_in;

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0] ctl_reg;
  logic [7:0] rie_reg;
  logic [15:0] bit_reg;

  // Control holds init request, wake-up enable and sleep request.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctl_reg <= `CTL_RESET;
    end else if (wr_en && req.addr == `CTL_OFFSET) begin
      ctl_reg <= req.data[7:0];
    end
  end
  assign init_request_out = ctl_reg[`CTL_INIT_REQ];
  assign sleep_request_out = ctl_reg[`CTL_SLEEP];

  // The enable register is also held in reset during init mode.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rie_reg <= `RIE_RESET;
    end else if (in_init) begin
      rie_reg <= `RIE_RESET;
    end else if (wr_en && out_init && req.addr == `RIE_OFFSET) begin
      rie_reg <= req.data[7:0];
    end
  end

  // Bit timing may only change in init mode: [15:10] prescaler, [6:4] seg2, [3:0] seg1.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_reg <= `BIT_RESET;
    end else if (wr_en && in_init && req.addr == `BIT_OFFSET) begin
      bit_reg <= req.data[15:0];
    end
  end

  // ****************************************
  // Bit time
  // ****************************************
  logic [6:0] prescale;
  logic [5:0] quanta;
  // Fields are stored minus one, so each adds one back.
  always_comb begin
    prescale = 7'(bit_reg[15:10]) + 7'd1;
    quanta = 6'd1 + 6'(bit_reg[3:0]) + 6'd1 + 6'(bit_reg[6:4]) + 6'd1;
  end
  // Registered to keep the multiply off the output path.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bit_time_ns_out <= 32'h0;
    end else begin
      bit_time_ns_out <= 32'((prescale * quanta * 1000) / `CAN_CLK_MHZ);
    end
  end

  // ****************************************
  // Error states
  // ****************************************
  err_state_e rx_actual;
  err_state_e tx_actual;
  err_state_e rx_shown_reg;
  err_state_e tx_shown_reg;
  logic rx_hit;
  logic tx_hit;

  err_state_decode #(.IS_RX(1'b1)) u_rx_decode (
    .own_count_in(evt.rx_err_count),
    .tx_count_in(evt.tx_err_count),
    .state_out(rx_actual)
  );
  err_state_decode #(.IS_RX(1'b0)) u_tx_decode (
    .own_count_in(evt.tx_err_count),
    .tx_count_in(evt.tx_err_count),
    .state_out(tx_actual)
  );
  state_change_detect u_rx_change (
    .sens_in(rie_reg[`FLD_RECEIVER_STATE_SENSITIVITY_HI:`FLD_RECEIVER_STATE_SENSITIVITY_LO]),
    .old_in(rx_shown_reg),
    .new_in(rx_actual),
    .hit_out(rx_hit)
  );
  state_change_detect u_tx_change (
    .sens_in(rie_reg[`FLD_TRANSMITTER_STATE_SENSITIVITY_HI:`FLD_TRANSMITTER_STATE_SENSITIVITY_LO]),
    .old_in(tx_shown_reg),
    .new_in(tx_actual),
    .hit_out(tx_hit)
  );

  // ****************************************
  // Flags
  // ****************************************
  logic wakeup_flag_reg;
  logic status_change_flag_reg;
  logic overrun_flag_reg;
  logic rx_buffer_full_flag_reg;
  logic flag_clr;
  logic [7:0] clr_bits;

  // Clears only count outside init and on a one.
  assign flag_clr = wr_en && out_init && req.addr == `RFS_OFFSET;
  assign clr_bits = flag_clr ? req.data[7:0] : 8'h00;

  // Shown states freeze while a status change is pending, so they keep
  // describing the change that raised the flag; init mode does not touch them.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_shown_reg <= ST_OK;
      tx_shown_reg <= ST_OK;
    end else if (!status_change_flag_reg) begin
      rx_shown_reg <= rx_actual;
      tx_shown_reg <= tx_actual;
    end
  end

  // Wake-up: the set wins over a clear, and a clear only holds once activity, sleep request or wake-up enable is gone.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wakeup_flag_reg <= 1'b0;
    end else if (in_init) begin
      wakeup_flag_reg <= 1'b0;
    end else if (evt.bus_activity && sleep_request_out && ctl_reg[`CTL_WAKE_EN]) begin
      wakeup_flag_reg <= 1'b1;
    end else if (clr_bits[`FLD_WAKEUP]) begin
      wakeup_flag_reg <= 1'b0;
    end
  end

  // Status change is raised only while no earlier one is pending.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_change_flag_reg <= 1'b0;
    end else if (in_init) begin
      status_change_flag_reg <= 1'b0;
    end else if (!status_change_flag_reg && (rx_hit || tx_hit)) begin
      status_change_flag_reg <= 1'b1;
    end else if (clr_bits[`FLD_STATUS]) begin
      status_change_flag_reg <= 1'b0;
    end
  end

  // Overrun flag.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      overrun_flag_reg <= 1'b0;
    end else if (in_init) begin
      overrun_flag_reg <= 1'b0;
    end else if (evt.overrun) begin
      overrun_flag_reg <= 1'b1;
    end else if (clr_bits[`FLD_OVERRUN]) begin
      overrun_flag_reg <= 1'b0;
    end
  end

  // A good frame is shifted only while the foreground is free; the
  // shift itself sets the full flag, so a clear cannot race it.
  assign shift_fg_out = evt.frame_ok && !rx_buffer_full_flag_reg && !in_init;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_buffer_full_flag_reg <= 1'b0;
    end else if (in_init) begin
      rx_buffer_full_flag_reg <= 1'b0;
    end else if (shift_fg_out) begin
      rx_buffer_full_flag_reg <= 1'b1;
    end else if (clr_bits[`FLD_RXFULL]) begin
      rx_buffer_full_flag_reg <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt requests
  // ****************************************
  // Requests are levels that stay up while flag and enable are both set.
  always_comb begin
    wakeup_irq_out = wakeup_flag_reg && rie_reg[`FLD_WAKEUP];
    error_irq_out = (status_change_flag_reg && rie_reg[`FLD_STATUS]) ||
                    (overrun_flag_reg && rie_reg[`FLD_OVERRUN]);
    receive_irq_out = rx_buffer_full_flag_reg && rie_reg[`FLD_RXFULL];
  end

  // ****************************************
  // Read data and acknowledge
  // ****************************************
  logic [7:0] flags_view;
  logic [31:0] rd_next;
  always_comb begin
    flags_view = {wakeup_flag_reg, status_change_flag_reg, rx_shown_reg, tx_shown_reg,
                  overrun_flag_reg, rx_buffer_full_flag_reg};
    case (req.addr)
      `RFS_OFFSET: rd_next = {24'h0, flags_view};
      `RIE_OFFSET: rd_next = {24'h0, rie_reg};
      `CTL_OFFSET: rd_next = {24'h0, ctl_reg[7:0]};
      `ERR_OFFSET: rd_next = {7'h0, evt.tx_err_count, 7'h0, evt.rx_err_count};
      `BIT_OFFSET: rd_next = {16'h0, bit_reg};
      default: rd_next = 32'h0;
    endcase
  end

  // One wait state: ack rises the cycle after the strobe, then drops.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_hit;
      wb_dat_out <= wb_hit ? rd_next : 32'h0;
    end
  end
endmodule // rx_flag_status

// ===== test/rx_flag_status_asserts.sv
// Concurrent checks on the ports of the receive flag block.
module rx_flag_status_asserts (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Reset.
  input wire logic wb_cyc_in, // Cycle.
  input wire logic wb_stb_in, // Strobe.
  input wire logic wb_we_in, // Write.
  input wire logic [31:0] wb_dat_out, // Read data.
  input wire logic wb_ack_out, // Acknowledge.
  input wire logic init_acknowledge_in, // Init acknowledge.
  input wire logic frame_ok_in, // Good frame waits.
  input wire logic shift_fg_out, // Shift pulse.
  input wire logic init_request_out, // Init request.
  input wire logic sleep_request_out, // Sleep request.
  input wire logic wakeup_irq_out, // Wake request.
  input wire logic error_irq_out, // Error request.
  input wire logic receive_irq_out // Receive request.
);
  // ****
  // Helpers
  // ****
  // Plain nets, so the sampled functions see no expressions.
  logic wr_done;
  logic init_mode;
  assign wr_done = wb_ack_out && wb_we_in;
  assign init_mode = init_request_out && init_acknowledge_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence req_taken;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence init_held;
    init_mode [*2];
  endsequence
  // ****
  // Checks
  // ****
  chk_ack_time: assert property (req_taken |=> wb_ack_out)
    else $error("ack not one cycle after request");
  chk_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == 32'h0)
    else $error("read data not zero outside ack");
  chk_shift_cause: assert property (shift_fg_out |-> frame_ok_in && !init_mode)
    else $error("shift without good frame");
  chk_shift_block: assert property (shift_fg_out |=> !shift_fg_out)
    else $error("shift while buffer full");
  chk_init_quiet: assert property (init_held |-> !wakeup_irq_out && !error_irq_out
    && !receive_irq_out)
    else $error("request pending in init mode");
  // A register write lands at the taking edge, so its effect shows while ack is up.
  chk_rx_rise: assert property ($rose(receive_irq_out) |-> $past(shift_fg_out)
    || wr_done)
    else $error("receive request without shift");
  chk_rx_fall: assert property ($fell(receive_irq_out) |-> wr_done
    || $past(init_mode))
    else $error("receive request dropped by itself");
  chk_err_fall: assert property ($fell(error_irq_out) |-> wr_done
    || $past(init_mode))
    else $error("error request dropped by itself");
  chk_wake_rise: assert property ($rose(wakeup_irq_out) |-> $past(sleep_request_out)
    || wr_done)
    else $error("wake request outside sleep");
  chk_reset_quiet: assert property ($past(rst_in) |-> !wb_ack_out && !wakeup_irq_out
    && !error_irq_out && !receive_irq_out)
    else $error("outputs active after reset");
endmodule // rx_flag_status_asserts
bind rx_flag_status rx_flag_status_asserts chk_i (.clk_in, .rst_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_dat_out, .wb_ack_out, .init_acknowledge_in, .frame_ok_in, .shift_fg_out,
  .init_request_out, .sleep_request_out, .wakeup_irq_out, .error_irq_out, .receive_irq_out);

// ===== test/can_side_model.sv
// Far-side model: queues correctly received frames until shifted.
module can_side_model (
  input wire logic clk_in, // Clock.
  input wire logic rst_in, // Reset.
  input wire logic push_in, // A frame ends on the bus.
  input wire logic good_in, // The frame passed all checks.
  input wire logic shift_in, // Head moved to foreground.
  output logic frame_ok_out, // Good frame waits at head.
  output logic overrun_out // Frame lost to a full queue.
);
  logic [1:0] pend_reg;
  logic take;
  logic slot;
  // Failed frames never enter, so they never reach the head.
  assign take = push_in && good_in;
  assign slot = take && (pend_reg != 2'h3 || shift_in);
  assign frame_ok_out = pend_reg != 2'h0;
  // Three slots only, so an overrun is reached in a few frames.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_reg <= 2'h0;
      overrun_out <= 1'b0;
    end else begin
      pend_reg <= pend_reg + 2'(slot) - 2'(shift_in);
      overrun_out <= take && !slot;
    end
  end
endmodule // can_side_model

// ===== test/tb_top.sv
// Self-checking bench for the receive flag block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, cyc, stb, we, ia, act, push, good, fok, ovr;
  logic ack, shf, ireq, sreq, wirq, eirq, rirq;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [8:0] rxc, txc;
  logic [31:0] wdat, rdat, rd_w, btime;
  int failures, check_count, shifts;
  // ****
  // Parts
  // ****
  rx_flag_status uut (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rd_w),
    .wb_ack_out(ack), .init_acknowledge_in(ia), .bus_activity_in(act), .frame_ok_in(fok),
    .overrun_in(ovr), .rx_err_count_in(rxc), .tx_err_count_in(txc), .shift_fg_out(shf),
    .init_request_out(ireq), .sleep_request_out(sreq), .bit_time_ns_out(btime),
    .wakeup_irq_out(wirq), .error_irq_out(eirq), .receive_irq_out(rirq));
  can_side_model far (.clk_in(clk_in), .rst_in(rst_in), .push_in(push), .good_in(good),
    .shift_in(shf), .frame_ok_out(fok), .overrun_out(ovr));
  // Clock at 100 MHz.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Shifts are counted at the edge that takes them.
  always @(posedge clk_in) begin
    if (shf === 1'b1) shifts++;
  end
  // ****
  // Tasks
  // ****
  task automatic close_out();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One classic cycle; the request is held until ack is sampled.
  task automatic wb(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      close_out();
    end
    rdat = rd_w;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic cnt(input int rx, input int tx);
    rxc <= 9'(rx);
    txc <= 9'(tx);
    tick(4);
  endtask
  // A cleared status flag may set again once, when the frozen state catches up.
  task automatic clr();
    wb(1, 5'h00, 16'h40);
    tick(4);
    wb(1, 5'h00, 16'h40);
  endtask
  task automatic frame(input logic g);
    push <= 1'b1;
    good <= g;
    tick(1);
    push <= 1'b0;
    tick(1);
  endtask
  function automatic logic [3:0] st(input int rx, input int tx);
    logic [1:0] r, t;
    t = tx > 255 ? 2'h3 : tx > 127 ? 2'h2 : tx > 96 ? 2'h1 : 2'h0;
    r = tx > 255 ? 2'h3 : rx > 127 ? 2'h2 : rx > 96 ? 2'h1 : 2'h0;
    return {r, t};
  endfunction
  // ****
  // Sequence
  // ****
  initial begin
    int i, a, b, c;
    int cor[6] = '{96, 97, 127, 128, 255, 256};
    {cyc, stb, we, ia, act, push, good} = 7'h0;
    adr = 5'h0;
    sel = 4'hF;
    wdat = 32'h0;
    rxc = 9'h0;
    txc = 9'h0;
    rst_in = 1'b1;
    void'($urandom(32'hEFDB7A9A));
    tick(4);
    rst_in <= 1'b0;
    tick(1);
    wb(0, 5'h00, 0); chk("flags", rdat, 0);
    wb(1, 5'h14, 16'hFF); wb(0, 5'h14, 0); chk("unmapped", rdat, 0);
    for (i = 0; i < 14; i++) begin
      a = i < 6 ? cor[i] : $urandom_range(511);
      b = i < 6 ? cor[i] : $urandom_range(511);
      cnt(a, b); wb(0, 5'h00, 0); chk("state", rdat[6:2], st(a, b));
    end
    for (i = 0; i < 4; i++) begin
      cnt(0, 0); clr(); wb(1, 5'h04, 16'(i << 4));
      cnt(100, 0); wb(0, 5'h00, 0); chk("warn", rdat[6], i == 3);
      cnt(200, 0); wb(0, 5'h00, 0);
      chk("err", rdat[6:4], i == 3 ? 3'h5 : {i > 1, 2'h2});
      clr();
    end
    wb(1, 5'h04, 16'h04); cnt(0, 300); wb(0, 5'h00, 0); chk("off", rdat[6:2], 5'h1F);
    cnt(0, 0); clr(); wb(0, 5'h00, 0); chk("on", rdat[6:2], 0);
    wb(1, 5'h04, 16'h83);
    frame(0); tick(4); wb(0, 5'h00, 0); chk("bad", rdat[0], 0);
    frame(1); frame(1); tick(4); wb(0, 5'h00, 0); chk("full", {rdat[0], rirq}, 3);
    chk("held", shifts, 1);
    wb(1, 5'h00, 16'h00); wb(0, 5'h00, 0); chk("zero", rdat[0], 1);
    wb(1, 5'h00, 16'h01); tick(2); chk("next", shifts, 2);
    wb(1, 5'h00, 16'h01); wb(0, 5'h00, 0); chk("empty", {rdat[0], rirq}, 0);
    repeat (5) frame(1);
    wb(0, 5'h00, 0); chk("ovr", {rdat[1], eirq}, 3);
    wb(1, 5'h00, 16'h02); wb(0, 5'h00, 0); chk("ovrclr", rdat[1], 0);
    wb(1, 5'h08, 16'h04); act <= 1'b1; tick(4); act <= 1'b0; tick(4);
    wb(0, 5'h00, 0); chk("nowake", rdat[7], 0);
    wb(1, 5'h08, 16'h06); act <= 1'b1; tick(6);
    wb(0, 5'h00, 0); chk("wake", {rdat[7], wirq}, 3);
    wb(1, 5'h00, 16'h80); wb(0, 5'h00, 0); chk("whold", rdat[7], 1);
    act <= 1'b0; wb(1, 5'h08, 0); wb(1, 5'h00, 16'h80);
    wb(0, 5'h00, 0); chk("wclr", rdat[7], 0);
    cnt(0, 100); wb(1, 5'h08, 16'h01); ia <= 1'b1; tick(3);
    wb(0, 5'h00, 0); chk("init", rdat, 32'h04);
    wb(1, 5'h04, 16'hFF); wb(0, 5'h04, 0); chk("rie", rdat, 0);
    for (i = 0; i < 5; i++) begin
      a = i ? $urandom_range(63) : 63;
      b = i ? $urandom_range(15) : 15;
      c = i ? $urandom_range(7) : 7;
      wb(1, 5'h10, {a[5:0], 3'h0, c[2:0], b[3:0]}); tick(2);
      chk("btime", btime, (a + 1) * (3 + b + c) * 10);
    end
    wb(1, 5'h08, 0); ia <= 1'b0; tick(2);
    wb(1, 5'h04, 16'h01); wb(0, 5'h04, 0); chk("rie2", rdat, 1);
    // A write whose low byte lane is not selected must leave the register alone.
    sel <= 4'h0; wb(1, 5'h04, 16'h02); sel <= 4'hF;
    wb(0, 5'h04, 0); chk("sel", rdat, 1);
    wb(1, 5'h00, 16'h3C); wb(0, 5'h00, 0); chk("ro", rdat[5:2], 4'h1);
    close_out();
  end
endmodule // tb_top
